// file: hdl/tpic_pkg.sv
package tpic_pkg;

  localparam logic [11:0] OFS_MODE     = 12'h000;
  localparam logic [11:0] OFS_START    = 12'h004;
  localparam logic [11:0] OFS_STOP     = 12'h008;
  localparam logic [11:0] OFS_ENSTAT   = 12'h00c;
  localparam logic [11:0] OFS_COUNT    = 12'h010;
  localparam logic [11:0] OFS_DATA     = 12'h014;
  localparam logic [11:0] OFS_STATUS   = 12'h018;
  localparam logic [11:0] OFS_UNIT     = 12'h01c;
  localparam logic [11:0] OFS_PRESCALE = 12'h020;
  localparam logic [11:0] OFS_NFILT    = 12'h024;
  localparam logic [11:0] OFS_OUTCTRL  = 12'h028;

  // Mode register field positions.
  localparam int POS_OPCLK    = 14;
  localparam int POS_CCS      = 12;
  localparam int POS_MSPLIT   = 11;
  localparam int POS_TRIG     = 8;
  localparam int POS_EDGE     = 6;
  localparam int POS_OPMODE   = 1;
  localparam int POS_STARTIRQ = 0;
  localparam logic [15:0] MODE_EDGE_MASK = 16'h00c0;

  localparam logic [2:0] OPMODE_CAPTURE = 3'h2;
  localparam logic [2:0] TRIG_PIN_EDGE  = 3'h1;
  localparam logic [1:0] EDGE_FALL      = 2'h0;
  localparam logic [1:0] EDGE_RISE      = 2'h1;
  localparam logic [1:0] EDGE_BOTH      = 2'h2;

  // Output control bit positions.
  localparam int POS_OUT_VALUE  = 0;
  localparam int POS_OUT_ENABLE = 1;
  localparam int POS_OUT_LEVEL  = 2;
  localparam int POS_OUT_MODE   = 3;

  localparam int POS_OVF = 0;

  localparam logic [15:0] RST_MODE     = 16'h0000;
  localparam logic [15:0] RST_COUNT    = 16'hffff;
  localparam logic [15:0] RST_DATA     = 16'h0000;
  localparam logic [15:0] RST_PRESCALE = 16'h0000;
  localparam logic [15:0] COUNT_CLEAR  = 16'h0000;
  localparam logic [15:0] COUNT_FULL   = 16'hffff;

endpackage

// file: hdl/tpic_top.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module tpic_top
  import tpic_pkg::*;
#(
  parameter int CHAN_NUM = 1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_in_pin,
  output logic             timer_out,
  output logic             chan_irq
);

  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [15:0] channel_mode_config_reg;
  logic        chan_enabled_stat_reg;
  logic        first_pending_reg;
  logic [15:0] count_reg;
  logic [15:0] capture_data_reg;
  logic        overflow_flag_reg;
  logic        ovf_pending_reg;
  logic        unit_clk_enable_reg;
  logic [15:0] prescale_select_reg;
  logic        noise_filter_enable_reg;
  logic [3:0]  out_ctrl_reg;
  logic [15:0] presc_cnt_reg;
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic        samp_reg;
  logic        filt_reg;
  logic        filt_d_reg;
  logic        irq_reg;
  logic        tout_reg;

  logic        wr_acc;
  logic        setup;
  logic        wr_start;
  logic        wr_stop;
  logic        op_tick;
  logic        cnt_tick;
  logic        pin_edge;
  logic        capture;
  logic        mode_ok;
  logic [1:0]  op_clk_sel;
  logic [1:0]  edge_sel;
  logic        running;
  logic        fresh_start;
  logic        cnt_wrap;

  function automatic logic presc_tick(input logic [15:0] cnt, input logic [3:0] pow);
    logic [15:0] mask;
    mask = 16'((17'h1 << pow) - 17'h1);
    return (cnt & mask) == mask;
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (a == OFS_MODE || a == OFS_START || a == OFS_STOP || a == OFS_ENSTAT) begin
      ok = 1'b1;
    end else if (a == OFS_COUNT || a == OFS_DATA || a == OFS_STATUS) begin
      ok = 1'b1;
    end else if (a == OFS_UNIT || a == OFS_PRESCALE || a == OFS_NFILT || a == OFS_OUTCTRL) begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  assign setup  = psel && !penable;
  // The unit enable register itself stays writable so software can turn the unit back on.
  assign wr_acc = psel && penable && pready_reg && pwrite;
  assign wr_start = wr_acc && unit_clk_enable_reg && paddr == OFS_START && pwdata[0];
  assign wr_stop  = wr_acc && unit_clk_enable_reg && paddr == OFS_STOP && pwdata[0];

  assign op_clk_sel = channel_mode_config_reg[POS_OPCLK +: 2];
  assign edge_sel   = channel_mode_config_reg[POS_EDGE +: 2];
  assign mode_ok = channel_mode_config_reg[POS_OPMODE +: 3] == OPMODE_CAPTURE
                   && !channel_mode_config_reg[POS_MSPLIT];

  // Channels other than 1 and 3 only have prescaled clocks 0 and 1, so the
  // low code bit is ignored there.
  always_comb begin
    logic [1:0] code;
    code = op_clk_sel;
    if (CHAN_NUM != 1 && CHAN_NUM != 3) begin
      code[0] = 1'b0;
    end
    case (code)
      2'h0:    op_tick = presc_tick(presc_cnt_reg, prescale_select_reg[3:0]);
      2'h2:    op_tick = presc_tick(presc_cnt_reg, prescale_select_reg[7:4]);
      2'h1:    op_tick = presc_tick(presc_cnt_reg, prescale_select_reg[11:8]);
      default: op_tick = presc_tick(presc_cnt_reg, prescale_select_reg[15:12]);
    endcase
    op_tick = op_tick && unit_clk_enable_reg;
  end

  always_comb begin
    pin_edge = 1'b0;
    if (filt_reg != filt_d_reg) begin
      case (edge_sel)
        EDGE_FALL: pin_edge = !filt_reg;
        EDGE_RISE: pin_edge = filt_reg;
        EDGE_BOTH: pin_edge = 1'b1;
        // Code 11 is not programmed by software, so it detects nothing.
        default:   pin_edge = 1'b0;
      endcase
    end
  end

  // With the select bit set the counter follows the valid pin edges instead.
  assign cnt_tick = channel_mode_config_reg[POS_CCS] ? pin_edge : op_tick;
  assign capture = chan_enabled_stat_reg && mode_ok
                   && ((pin_edge && channel_mode_config_reg[POS_TRIG +: 3] == TRIG_PIN_EDGE)
                       || wr_start);

  // A stop request in the same cycle as a capture wins for count, data and flag; the capture interrupt still fires.
  assign running     = chan_enabled_stat_reg && mode_ok && !wr_stop;
  assign fresh_start = wr_start && !chan_enabled_stat_reg;
  assign cnt_wrap    = cnt_tick && !first_pending_reg && count_reg == COUNT_FULL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !addr_mapped(paddr);
      prdata_reg  <= 32'h0000_0000;
      // Read data is taken at the setup edge, so it stands for the whole access cycle.
      // Registers outside the map read as zero and are flagged with an error.
      if (setup && !pwrite) begin
        if (paddr == OFS_MODE) begin
          prdata_reg <= {16'h0000, channel_mode_config_reg};
        end else if (paddr == OFS_ENSTAT) begin
          prdata_reg <= {31'h0000_0000, chan_enabled_stat_reg};
        end else if (paddr == OFS_COUNT) begin
          prdata_reg <= {16'h0000, count_reg};
        end else if (paddr == OFS_DATA) begin
          prdata_reg <= {16'h0000, capture_data_reg};
        end else if (paddr == OFS_STATUS) begin
          prdata_reg <= {31'h0000_0000, overflow_flag_reg};
        end else if (paddr == OFS_UNIT) begin
          prdata_reg <= {31'h0000_0000, unit_clk_enable_reg};
        end else if (paddr == OFS_PRESCALE) begin
          prdata_reg <= {16'h0000, prescale_select_reg};
        end else if (paddr == OFS_NFILT) begin
          prdata_reg <= {31'h0000_0000, noise_filter_enable_reg};
        end else if (paddr == OFS_OUTCTRL) begin
          prdata_reg <= {28'h000_0000, out_ctrl_reg};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_clk_enable_reg <= 1'b0;
    end else if (wr_acc && paddr == OFS_UNIT) begin
      unit_clk_enable_reg <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_mode_config_reg <= RST_MODE;
      prescale_select_reg     <= RST_PRESCALE;
      noise_filter_enable_reg <= 1'b0;
      out_ctrl_reg            <= 4'h0;
    end else if (!unit_clk_enable_reg) begin
      channel_mode_config_reg <= RST_MODE;
      prescale_select_reg     <= RST_PRESCALE;
      noise_filter_enable_reg <= 1'b0;
      out_ctrl_reg            <= 4'h0;
    end else if (wr_acc) begin
      if (paddr == OFS_MODE) begin
        if (chan_enabled_stat_reg) begin
          channel_mode_config_reg <= (channel_mode_config_reg & ~MODE_EDGE_MASK)
                                     | (pwdata[15:0] & MODE_EDGE_MASK);
        end else begin
          channel_mode_config_reg <= pwdata[15:0];
        end
      end else if (paddr == OFS_PRESCALE) begin
        prescale_select_reg <= pwdata[15:0];
      end else if (paddr == OFS_NFILT) begin
        noise_filter_enable_reg <= pwdata[0];
      end else if (paddr == OFS_OUTCTRL && !chan_enabled_stat_reg) begin
        out_ctrl_reg <= pwdata[3:0];
      end
    end
  end

  // One free-running counter serves all four prescaled clocks, which keeps them in phase.
  // A zero field makes that clock tick on every pclk edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_reg <= 16'h0000;
    end else if (!unit_clk_enable_reg) begin
      presc_cnt_reg <= 16'h0000;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 16'h0001;
    end
  end

  // Two flip-flops bring the pin into the pclk domain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= timer_in_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // The filter demands two equal operation-clock samples, adding one tick of lag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_reg   <= 1'b0;
      filt_reg   <= 1'b0;
      filt_d_reg <= 1'b0;
    end else if (!unit_clk_enable_reg) begin
      samp_reg   <= 1'b0;
      filt_reg   <= 1'b0;
      filt_d_reg <= 1'b0;
    end else begin
      filt_d_reg <= filt_reg;
      if (op_tick) begin
        samp_reg <= pin_sync_reg;
        if (!noise_filter_enable_reg) begin
          filt_reg <= pin_sync_reg;
        end else if (samp_reg == pin_sync_reg) begin
          filt_reg <= samp_reg;
        end
      end
    end
  end

  // Stop outranks start; one transfer carries only one of them, so the order only matters
  // if both trigger bits are ever mapped to the same word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_enabled_stat_reg <= 1'b0;
    end else if (!unit_clk_enable_reg) begin
      chan_enabled_stat_reg <= 1'b0;
    end else if (wr_stop) begin
      chan_enabled_stat_reg <= 1'b0;
    end else if (wr_start) begin
      chan_enabled_stat_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pending_reg <= 1'b0;
      count_reg         <= RST_COUNT;
    end else if (!unit_clk_enable_reg) begin
      first_pending_reg <= 1'b0;
      count_reg         <= RST_COUNT;
    end else if (fresh_start) begin
      first_pending_reg <= 1'b1;
    end else if (running) begin
      if (capture) begin
        count_reg         <= COUNT_CLEAR;
        first_pending_reg <= 1'b0;
      end else if (cnt_tick) begin
        if (first_pending_reg) begin
          count_reg         <= COUNT_CLEAR;
          first_pending_reg <= 1'b0;
        end else begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_data_reg <= RST_DATA;
    end else if (!unit_clk_enable_reg) begin
      capture_data_reg <= RST_DATA;
    end else if (running && capture) begin
      capture_data_reg <= count_reg;
    end
  end

  // The flag keeps its value over a restart; only the pending wrap is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_reg <= 1'b0;
      ovf_pending_reg   <= 1'b0;
    end else if (!unit_clk_enable_reg) begin
      overflow_flag_reg <= 1'b0;
      ovf_pending_reg   <= 1'b0;
    end else if (fresh_start) begin
      ovf_pending_reg <= 1'b0;
    end else if (running && capture) begin
      overflow_flag_reg <= ovf_pending_reg || cnt_wrap;
      ovf_pending_reg   <= 1'b0;
    end else if (running && cnt_wrap) begin
      ovf_pending_reg <= 1'b1;
    end
  end

  // The start interrupt also needs a valid capture setup, so a start with a wrong mode
  // code raises nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= capture
                 || (wr_start && !chan_enabled_stat_reg && mode_ok
                     && channel_mode_config_reg[POS_STARTIRQ]);
    end
  end

  // The counter never drives the output; only the software value bit reaches the pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_reg <= 1'b0;
    end else begin
      tout_reg <= out_ctrl_reg[POS_OUT_VALUE] && out_ctrl_reg[POS_OUT_ENABLE]
                  && !chan_enabled_stat_reg;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign chan_irq  = irq_reg;
  assign timer_out = tout_reg;

endmodule
`default_nettype wire

// file: tb/tpic_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module tpic_top_chk
  import tpic_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_out,
  input wire logic        chan_irq
);
  logic        unit_q;
  logic        run_q;
  logic [15:0] mode_q;
  logic        wacc;
  logic        go;
  logic        halt;
  assign wacc = psel && penable && pready && pwrite;
  assign go = wacc && paddr == OFS_START && pwdata[0] && unit_q;
  assign halt = wacc && (paddr == OFS_STOP ? pwdata[0] : paddr == OFS_UNIT && !pwdata[0]);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_q <= 1'b0;
    end else if (wacc && paddr == OFS_UNIT) begin
      unit_q <= pwdata[0];
    end
  end
  // Mirrored only while stopped, since a running channel takes the edge bits alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 16'h0000;
    end else if (wacc && paddr == OFS_UNIT && !pwdata[0]) begin
      mode_q <= 16'h0000;
    end else if (wacc && paddr == OFS_MODE && unit_q && !run_q) begin
      mode_q <= pwdata[15:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else if (halt) begin
      run_q <= 1'b0;
    end else if (go) begin
      run_q <= 1'b1;
    end
  end
  a_ready_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_start_irq: assert property (go && !run_q && mode_q[0] && mode_q[3:1] == OPMODE_CAPTURE
    && mode_q[10:8] == TRIG_PIN_EDGE && !mode_q[11] |-> ##[1:2] chan_irq)
    else $error("no interrupt at counting start");
  a_irq_single: assert property (chan_irq |=> !chan_irq)
    else $error("interrupt is not a pulse");
  a_irq_running: assert property (chan_irq |-> run_q || $past(run_q) || $past(run_q, 2))
    else $error("interrupt from a stopped channel");
  a_stop_quiet: assert property (halt && unit_q |-> ##3 !chan_irq [*4])
    else $error("interrupt after stop");
  a_out_quiet: assert property (run_q && $past(run_q) |-> !timer_out)
    else $error("output driven while counting");
  a_read_hi_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  c_irq: cover property (chan_irq);
  c_err: cover property (pslverr);
  c_stop: cover property (halt && unit_q);
endmodule
bind tpic_top tpic_top_chk i_tpic_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_out(timer_out), .chan_irq(chan_irq));
`default_nettype wire

// file: tb/tpic_pulse_src.sv
`timescale 1ns/100ps
`default_nettype none
module tpic_pulse_src (
  input  wire logic        pclk,
  input  wire logic        on,
  input  wire logic [15:0] half,
  output logic             pin
);
  logic [15:0] cnt = 16'h0000;
  initial pin = 1'b0;
  // Edges lie on whole clock cycles, so every interval is known exactly.
  always @(posedge pclk) begin
    if (!on) begin
      cnt <= 16'h0000;
    end else if (cnt == half - 16'h0001) begin
      cnt <= 16'h0000;
      pin <= !pin;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: tb/tpic_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module tpic_top_test
  import tpic_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        timer_out;
  logic        chan_irq;
  logic        on = 1'b0;
  logic [31:0] rdat;
  logic [31:0] v;
  logic        rerr;
  int          failures = 0;
  int          comparisons = 0;
  int          irqs = 0;
  int          cyc = 0;
  int          n;
  always #2 pclk = ~pclk;
  tpic_top i_tpic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_in_pin(pin), .timer_out(timer_out), .chan_irq(chan_irq));
  tpic_pulse_src i_tpic_pulse_src (.pclk(pclk), .on(on), .half(16'h0014), .pin(pin));
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (chan_irq === 1'b1) begin
      irqs <= irqs + 1;
    end
    if (cyc == 80000) begin
      failures = failures + 1;
      test_done();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons = comparisons + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp($sformatf("reg %h", a), e, rdat);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFS_MODE, 32'h0145);
    chk(OFS_MODE, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    cmp("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b1, OFS_UNIT, 32'h1);
    apb(1'b1, OFS_MODE, 32'h0145);
    chk(OFS_MODE, 32'h0145);
    n = irqs;
    apb(1'b1, OFS_START, 32'h1);
    chk(OFS_ENSTAT, 32'h1);
    chk(OFS_START, 32'h0);
    cmp("start irq", n + 1, irqs);
    on <= 1'b1;
    // Edge select is the one mode field that may move while the channel counts.
    for (int e = 0; e < 3; e++) begin
      apb(1'b1, OFS_MODE, 32'h0105 | (e << 6));
      repeat (200) @(posedge pclk);
      chk(OFS_DATA, (e == 2) ? 32'h13 : 32'h27);
      chk(OFS_STATUS, 32'h0);
    end
    on <= 1'b0;
    repeat (66000) @(posedge pclk);
    on <= 1'b1;
    @(pin);
    repeat (8) @(posedge pclk);
    chk(OFS_STATUS, 32'h1);
    repeat (40) @(posedge pclk);
    chk(OFS_STATUS, 32'h0);
    on <= 1'b0;
    repeat (10) @(posedge pclk);
    n = irqs;
    apb(1'b1, OFS_START, 32'h1);
    repeat (4) @(posedge pclk);
    cmp("soft capture irq", n + 1, irqs);
    apb(1'b1, OFS_STOP, 32'h1);
    chk(OFS_ENSTAT, 32'h0);
    apb(1'b0, OFS_COUNT, 32'h0);
    v = rdat;
    repeat (50) @(posedge pclk);
    chk(OFS_COUNT, v);
    apb(1'b1, OFS_UNIT, 32'h0);
    apb(1'b1, OFS_UNIT, 32'h1);
    chk(OFS_COUNT, {16'h0, RST_COUNT});
    chk(OFS_MODE, {16'h0, RST_MODE});
    apb(1'b1, OFS_OUTCTRL, 32'h3);
    repeat (2) @(posedge pclk);
    cmp("stopped output", 32'h1, {31'h0, timer_out});
    // Prescaled clock 0 at half rate through the filter: 20 ticks per 40-cycle interval.
    apb(1'b1, OFS_PRESCALE, 32'h1);
    apb(1'b1, OFS_NFILT, 32'h1);
    apb(1'b1, OFS_MODE, 32'h0145);
    apb(1'b1, OFS_START, 32'h1);
    on <= 1'b1;
    repeat (200) @(posedge pclk);
    chk(OFS_DATA, 32'h14);
    apb(1'b1, OFS_OUTCTRL, 32'h0);
    chk(OFS_OUTCTRL, 32'h3);
    cmp("running output", 32'h0, {31'h0, timer_out});
    test_done();
  end
endmodule
`default_nettype wire
